//--- hdl/timer_baud_pkg.sv
// package: register map, field positions and reset values of the baud/clock-out timer
package timer_baud_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] MODE_ADDR = 8'h04;
    localparam logic [7:0] COUNT_ADDR = 8'h08;
    localparam logic [7:0] RELOAD_ADDR = 8'h0c;
    localparam logic [7:0] IEN_ADDR = 8'h10;
    // ------------------------------------------------------------
    // timer_control_reg fields
    // ------------------------------------------------------------
    localparam int CTRL_OVF = 7;
    localparam int CTRL_EXTF = 6;
    localparam int CTRL_RXSEL = 5;
    localparam int CTRL_TXSEL = 4;
    localparam int CTRL_EXTEN = 3;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_CT = 1;
    localparam int CTRL_CPRL = 0;
    // mode register fields
    localparam int MODE_CLKOE = 1;
    localparam int MODE_BYPASS = 2;
    // interrupt enable register fields
    localparam int IEN_GLOBAL = 1;
    localparam int IEN_TIMER = 0;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    localparam logic [15:0] RELOAD_MIN = 16'h0010;
    localparam int PRESCALE_DIV = 12;
endpackage

//--- hdl/timer_prescaler.sv
// prescaler: one-cycle tick every DIV clocks, or every clock in bypass
`timescale 1ns/100ps
module timer_prescaler #(
    parameter int DIV = 12
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic bypass,
    output logic tick
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    initial begin
        if (DIV < 2) begin
            $error("prescaler divide must be at least 2");
        end
    end

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (bypass) begin
            nxt_cnt = '0;
            nxt_tick = 1'b1;
        end else if (cnt_ff == CW'(DIV - 1)) begin
            nxt_cnt = '0;
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

//--- hdl/timer_baud_clkout.sv
// timer with baud generator, clock output and shared interrupt flags, APB slave
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
module timer_baud_clkout
    import timer_baud_pkg::*;
#(
    parameter int PRESCALE = timer_baud_pkg::PRESCALE_DIV
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extTriggerPin,
    input wire logic timerIoPinIn,
    output logic timerIoPinOut,
    output logic timerIoPinOe,
    input wire logic otherTimerBaudTick,
    input wire logic [1:0] serialMode,
    output logic txBaudTick,
    output logic rxBaudTick,
    output logic timerIrq
);
    import timer_baud_pkg::*;

    initial begin
        if (PRESCALE < 2) begin
            $error("prescale divide must be at least 2");
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic clkOe_ff;
    logic nxt_clkOe;
    logic bypass_ff;
    logic nxt_bypass;
    logic [1:0] ien_ff;
    logic [1:0] nxt_ien;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic [15:0] reload_ff;
    logic [15:0] nxt_reload;
    logic extSync_ff;
    logic extPrev_ff;
    logic pinSync_ff;
    logic pinPrev_ff;
    logic clkOut_ff;
    logic nxt_clkOut;
    // only every second overflow toggles the pin, giving the x4 divide
    logic halfPhase_ff;
    logic nxt_halfPhase;
    logic txTick_ff;
    logic nxt_txTick;
    logic rxTick_ff;
    logic nxt_rxTick;
    logic irq_ff;
    logic nxt_irq;
    logic oe_ff;
    logic nxt_oe;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic ready_ff;
    logic nxt_ready;
    logic err_ff;
    logic nxt_err;
    logic tick;

    timer_prescaler #(.DIV(PRESCALE)) u_prescale (
        .ref_clk(ref_clk),
        .reset(reset),
        .bypass(bypass_ff),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // mode decode and counting
    // ------------------------------------------------------------
    logic baudMode;
    logic clkOutMode;
    logic counterMode;
    logic run;
    logic countEn;
    logic overflow;
    logic extFall;
    logic pinRise;
    logic wr, rd, hit;
    logic [15:0] reloadOrWr;

    always_comb begin
        baudMode = ctrl_ff[CTRL_TXSEL] | ctrl_ff[CTRL_RXSEL];
        clkOutMode = clkOe_ff & ~ctrl_ff[CTRL_CT];
        counterMode = ctrl_ff[CTRL_CT] & ~clkOe_ff;
        run = ctrl_ff[CTRL_RUN];
        extFall = extPrev_ff & ~extSync_ff;
        pinRise = ~pinPrev_ff & pinSync_ff;
        // baud mode counts the system rate unless counter or clock-out mode is also set; clock-out and plain timer modes the prescaled tick, counter mode the pin
        if (!run) begin
            countEn = 1'b0;
        end else if (counterMode) begin
            countEn = pinRise;
        end else if (baudMode && !clkOutMode) begin
            countEn = 1'b1;
        end else begin
            countEn = tick;
        end
        overflow = countEn & (count_ff == COUNT_TOP);
        // a write lands at the edge that ends the access phase, pready high
        wr = psel & penable & pwrite & ready_ff;
        rd = psel & ~penable;
        hit = (paddr == CTRL_ADDR) | (paddr == MODE_ADDR) | (paddr == COUNT_ADDR)
            | (paddr == RELOAD_ADDR) | (paddr == IEN_ADDR);
        reloadOrWr = reload_ff;
    end

    // ------------------------------------------------------------
    // registers, flags and counter next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_clkOe = clkOe_ff;
        nxt_bypass = bypass_ff;
        nxt_ien = ien_ff;
        nxt_reload = reload_ff;
        nxt_count = count_ff;
        nxt_clkOut = clkOut_ff;
        nxt_halfPhase = halfPhase_ff;
        if (overflow) begin
            nxt_count = reloadOrWr;
            if (clkOutMode) begin
                nxt_halfPhase = ~halfPhase_ff;
                if (halfPhase_ff) begin
                    nxt_clkOut = ~clkOut_ff;
                end
            end
        end else if (countEn) begin
            nxt_count = count_ff + 16'h0001;
        end
        if (!clkOutMode) begin
            nxt_clkOut = 1'b0;
            nxt_halfPhase = 1'b0;
        end
        // reload on external edge only outside baud and clock modes
        if (extFall && ctrl_ff[CTRL_EXTEN] && !baudMode && !clkOutMode
            && !ctrl_ff[CTRL_CPRL]) begin
            nxt_count = reload_ff;
        end
        if (wr) begin
            unique case (paddr)
                CTRL_ADDR: nxt_ctrl = pwdata[7:0];
                MODE_ADDR: begin
                    nxt_clkOe = pwdata[MODE_CLKOE];
                    nxt_bypass = pwdata[MODE_BYPASS];
                end
                COUNT_ADDR: nxt_count = pwdata[15:0];
                RELOAD_ADDR: nxt_reload = pwdata[15:0];
                IEN_ADDR: nxt_ien = pwdata[1:0];
                default: ;
            endcase
        end
        // hardware sets win over a clearing write in the same cycle
        if (overflow && !baudMode && !clkOutMode) begin
            nxt_ctrl[CTRL_OVF] = 1'b1;
        end
        if (extFall && ctrl_ff[CTRL_EXTEN]) begin
            nxt_ctrl[CTRL_EXTF] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs: baud ticks, pin, interrupt, apb answer
    // ------------------------------------------------------------
    always_comb begin
        // transmitter and receiver ticks only in serial modes 1 and 3
        nxt_txTick = ctrl_ff[CTRL_TXSEL] ? (overflow & baudMode) : otherTimerBaudTick;
        nxt_rxTick = ctrl_ff[CTRL_RXSEL] ? (overflow & baudMode) : otherTimerBaudTick;
        if (!serialMode[0]) begin
            nxt_txTick = 1'b0;
            nxt_rxTick = 1'b0;
        end
        nxt_irq = (nxt_ctrl[CTRL_OVF] | nxt_ctrl[CTRL_EXTF])
            & nxt_ien[IEN_GLOBAL] & nxt_ien[IEN_TIMER];
        nxt_oe = clkOutMode;
        nxt_ready = psel & ~penable;
        nxt_err = rd & ~hit;
        nxt_rdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                CTRL_ADDR: nxt_rdata = {24'h000000, ctrl_ff};
                MODE_ADDR: nxt_rdata = {29'h0, bypass_ff, clkOe_ff, 1'b0};
                COUNT_ADDR: nxt_rdata = {16'h0000, count_ff};
                RELOAD_ADDR: nxt_rdata = {16'h0000, reload_ff};
                IEN_ADDR: nxt_rdata = {30'h0, ien_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        // data and error stand for the access cycle only, with pready
    end

    // ------------------------------------------------------------
    // register file, counter and clock-out state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_ff <= CTRL_RESET;
            clkOe_ff <= 1'b0;
            bypass_ff <= 1'b0;
            ien_ff <= 2'h0;
            count_ff <= COUNT_RESET;
            reload_ff <= RELOAD_RESET;
            clkOut_ff <= 1'b0;
            halfPhase_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            clkOe_ff <= nxt_clkOe;
            bypass_ff <= nxt_bypass;
            ien_ff <= nxt_ien;
            count_ff <= nxt_count;
            reload_ff <= nxt_reload;
            clkOut_ff <= nxt_clkOut;
            halfPhase_ff <= nxt_halfPhase;
        end
    end

    // ------------------------------------------------------------
    // edge detectors on the trigger and timer pins
    // ------------------------------------------------------------
    // trigger idles high; resetting high avoids a false fall after reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            extSync_ff <= 1'b1;
            extPrev_ff <= 1'b1;
            pinSync_ff <= 1'b0;
            pinPrev_ff <= 1'b0;
        end else begin
            extSync_ff <= extTriggerPin;
            extPrev_ff <= extSync_ff;
            pinSync_ff <= timerIoPinIn;
            pinPrev_ff <= pinSync_ff;
        end
    end

    // ------------------------------------------------------------
    // serial ticks, interrupt and pin enable
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            txTick_ff <= 1'b0;
            rxTick_ff <= 1'b0;
            irq_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            txTick_ff <= nxt_txTick;
            rxTick_ff <= nxt_rxTick;
            irq_ff <= nxt_irq;
            oe_ff <= nxt_oe;
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
        end
    end

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign timerIoPinOut = clkOut_ff;
    assign timerIoPinOe = oe_ff;
    assign txBaudTick = txTick_ff;
    assign rxBaudTick = rxTick_ff;
    assign timerIrq = irq_ff;
endmodule

//--- verif/timer_baud_chk.sv
// checker: port-level relations of the baud/clock-out timer
`timescale 1ns/100ps
module timer_baud_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timerIoPinOut,
    input wire logic timerIoPinOe,
    input wire logic [1:0] serialMode,
    input wire logic txBaudTick,
    input wire logic rxBaudTick,
    input wire logic timerIrq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err; pslverr |-> pready && !pwrite && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error response");
    property p_pin; !timerIoPinOe |-> !timerIoPinOut; endproperty
    a_pin: assert property (p_pin) else $error("pin driven while off");
    property p_tx; txBaudTick |-> $past(serialMode[0]); endproperty
    a_tx: assert property (p_tx) else $error("tx tick in wrong mode");
    property p_rx; rxBaudTick |-> $past(serialMode[0]); endproperty
    a_rx: assert property (p_rx) else $error("rx tick in wrong mode");
    property p_pulse; txBaudTick |=> !txBaudTick; endproperty
    a_pulse: assert property (p_pulse) else $error("tx tick too long");
    property p_irq;
        timerIrq && !(psel && pwrite) && !$past(psel && pwrite) |=> timerIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq dropped alone");
endmodule
bind timer_baud_clkout timer_baud_chk chk_u (.ref_clk, .reset, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .timerIoPinOut, .timerIoPinOe, .serialMode,
    .txBaudTick, .rxBaudTick, .timerIrq);

//--- verif/serial_port_model.sv
// partner: serial port end and the other timer's baud source
`timescale 1ns/100ps
module serial_port_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic txBaudTick,
    input wire logic rxBaudTick,
    output logic otherTimerBaudTick = 1'h0,
    output int txCnt,
    output int rxCnt
);
    int div = 0;
    // other timer pulses every 5 clocks
    always @(posedge ref_clk) begin
        div <= (reset || div == 4) ? 0 : div + 1;
        otherTimerBaudTick <= !reset && div == 4;
        txCnt <= reset ? 0 : txCnt + txBaudTick;
        rxCnt <= reset ? 0 : rxCnt + rxBaudTick;
    end
endmodule

//--- verif/timer_baud_clkout_bench.sv
// testbench: register-level scenarios for the baud/clock-out timer
`timescale 1ns/100ps
module timer_baud_clkout_bench;
    import timer_baud_pkg::*;
    logic ref_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, extTriggerPin = 1'h1, timerIoPinOut, timerIoPinOe;
    logic otherTimerBaudTick, txBaudTick, rxBaudTick, timerIrq;
    logic [1:0] serialMode = 2'h1;
    int error_cnt = 0, samples_checked = 0, txCnt, rxCnt, n, t0;
    always #50 ref_clk = ~ref_clk;
    timer_baud_clkout dut_u (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .extTriggerPin, .timerIoPinIn(1'h0),
        .timerIoPinOut, .timerIoPinOe, .otherTimerBaudTick, .serialMode,
        .txBaudTick, .rxBaudTick, .timerIrq);
    serial_port_model peer_u (.ref_clk, .reset, .txBaudTick, .rxBaudTick,
        .otherTimerBaudTick, .txCnt, .rxCnt);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task end_sim;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            error_cnt++;
            end_sim;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task rdr(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    function automatic logic [31:0] bt(int b);
        return 32'h1 << b;
    endfunction
    function automatic logic pick(int s);
        return s == 0 ? txBaudTick : s == 1 ? rxBaudTick : timerIoPinOut;
    endfunction
    // cycles between two rising edges of the picked signal
    task per(input int s, output int p);
        logic q, prev;
        int k, e;
        e = 0;
        p = 0;
        prev = 1'h1;
        for (k = 0; k < 3000 && e < 2; k++) begin
            @(negedge ref_clk);
            q = pick(s);
            if (q && !prev) begin
                e++;
                if (e == 1) t0 = k;
                p = k - t0;
            end
            prev = q;
        end
        // hand back on a rising edge, where callers drive their stimulus
        @(posedge ref_clk);
        if (e < 2) begin
            error_cnt++;
            end_sim;
        end
    endtask
    task fall_pin;
        extTriggerPin <= 1'h0;
        repeat (3) @(posedge ref_clk);
        extTriggerPin <= 1'h1;
        repeat (4) @(posedge ref_clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'h0;
        rdr(CTRL_ADDR);
        chk("ctrl reset", rd, {24'h0, CTRL_RESET});
        rdr(8'h3c);
        chk("unmapped err", err, 1'h1);
        // reload kept above the floor, written only while stopped
        wr(COUNT_ADDR, 32'hfff0);
        wr(RELOAD_ADDR, 32'hfff0);
        wr(CTRL_ADDR, bt(CTRL_TXSEL) | bt(CTRL_RUN));
        per(0, n);
        chk("tx period", n, 16);
        per(1, n);
        chk("rx from other", n, 5);
        wr(CTRL_ADDR, bt(CTRL_TXSEL) | bt(CTRL_RXSEL) | bt(CTRL_RUN));
        per(1, n);
        chk("rx period", n, 16);
        serialMode <= 2'h2;
        repeat (3) @(posedge ref_clk);
        t0 = txCnt;
        n = rxCnt;
        repeat (40) @(posedge ref_clk);
        chk("mode 2 ticks", txCnt - t0, 0);
        chk("mode 2 rx ticks", rxCnt - n, 0);
        serialMode <= 2'h3;
        per(0, n);
        chk("mode 3 period", n, 16);
        wr(CTRL_ADDR, bt(CTRL_TXSEL) | bt(CTRL_RUN) | bt(CTRL_EXTEN));
        fall_pin;
        rdr(CTRL_ADDR);
        chk("ext flag", rd[CTRL_EXTF], 1'h1);
        chk("no ovf flag", rd[CTRL_OVF], 1'h0);
        per(0, n);
        chk("tx after ext", n, 16);
        wr(IEN_ADDR, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk("irq on", timerIrq, 1'h1);
        wr(IEN_ADDR, bt(IEN_TIMER));
        repeat (2) @(posedge ref_clk);
        chk("irq masked", timerIrq, 1'h0);
        wr(IEN_ADDR, 32'h3);
        wr(CTRL_ADDR, bt(CTRL_TXSEL) | bt(CTRL_RUN));
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", timerIrq, 1'h0);
        // stopped baud timer keeps tx select, so no tx ticks; trigger still live
        wr(CTRL_ADDR, bt(CTRL_TXSEL) | bt(CTRL_OVF) | bt(CTRL_EXTEN));
        repeat (2) @(posedge ref_clk);
        chk("sw flag irq", timerIrq, 1'h1);
        t0 = txCnt;
        fall_pin;
        repeat (30) @(posedge ref_clk);
        chk("stopped ticks", txCnt - t0, 0);
        rdr(CTRL_ADDR);
        chk("stop ext flag", rd[CTRL_EXTF], 1'h1);
        chk("ovf kept", rd[CTRL_OVF], 1'h1);
        wr(CTRL_ADDR, 32'h0);
        wr(COUNT_ADDR, 32'hfffc);
        wr(RELOAD_ADDR, 32'hfffc);
        wr(MODE_ADDR, bt(MODE_CLKOE) | bt(MODE_BYPASS));
        wr(CTRL_ADDR, bt(CTRL_RUN));
        per(2, n);
        chk("clk out fast", n, 16);
        chk("pin enable", timerIoPinOe, 1'h1);
        wr(MODE_ADDR, bt(MODE_CLKOE));
        per(2, n);
        chk("clk out /12", n, 192);
        rdr(CTRL_ADDR);
        chk("clkout no ovf", rd[CTRL_OVF], 1'h0);
        end_sim;
    end
endmodule
